/* File: cbu_branch_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// protocol checker for the conditional branch unit
// ----------
module cbu_branch_asserts
#(
   parameter int PC_WIDTH = cbu_pkg::CBU_PC_WIDTH,
   parameter int K_WIDTH = cbu_pkg::CBU_K_WIDTH
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire cbu_pkg::cbu_cond_type instr_cond,
   input wire logic [K_WIDTH-1:0] instr_offset,
   input wire logic [PC_WIDTH-1:0] program_counter,
   input wire logic flag_carry,
   input wire logic flag_negative,
   input wire logic flag_overflow,
   input wire logic flag_halfcarry,
   input wire logic flag_transfer,
   input wire logic pc_load,
   input wire logic [PC_WIDTH-1:0] pc_target,
   input wire logic fetch_flush,
   input wire logic pipe_stall,
   input wire logic branch_done,
   input wire logic branch_taken,
   input wire logic flag_write_en,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   import cbu_pkg::*;
   logic hit; // condition of the code now presented
   logic [PC_WIDTH-1:0] want; // target for the code now presented
   assign want = program_counter + PC_WIDTH'($signed(instr_offset)) + 1'b1;
   // flag test kept apart from the design's own evaluator
   always_comb
   begin
      case (instr_cond)
         branch_carry_set, branch_lower: hit = flag_carry;
         branch_carry_clear, branch_same_or_higher: hit = !flag_carry;
         branch_negative: hit = flag_negative;
         branch_positive: hit = !flag_negative;
         branch_signed_ge: hit = !(flag_negative ^ flag_overflow);
         branch_signed_lt: hit = flag_negative ^ flag_overflow;
         branch_halfcarry_set: hit = flag_halfcarry;
         branch_halfcarry_clear: hit = !flag_halfcarry;
         branch_transfer_set: hit = flag_transfer;
         default: hit = 1'b0;
      endcase
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------
   // redirect steps
   // ----------
   sequence s_redirect;
      fetch_flush && pipe_stall && branch_taken;
   endsequence
   sequence s_settle;
      !pc_load && !pipe_stall && branch_done;
   endsequence
   a_target_sum: assert property (pc_load |-> pc_target == $past(want))
      else $error("redirect target wrong");
   a_taken_hit: assert property (pc_load |-> $past(instr_valid) && $past(hit))
      else $error("branch taken on failed condition");
   a_fall_miss: assert property (branch_done && !$past(pipe_stall)
      |-> $past(instr_valid) && !$past(hit))
      else $error("held condition fell through");
   a_redirect_seq: assert property (pc_load |-> s_redirect ##1 s_settle)
      else $error("redirect sequence wrong");
   a_done_cause: assert property (branch_done
      |-> $past(instr_valid) || $past(pc_load))
      else $error("done without a branch");
   a_flag_quiet: assert property (!flag_write_en)
      else $error("status flags written");
   a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus request not answered");
endmodule : cbu_branch_asserts
bind cbu_branch_unit cbu_branch_asserts
   #(.PC_WIDTH(PC_WIDTH), .K_WIDTH(K_WIDTH)) u_asserts
   (
      .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr_cond(instr_cond), .instr_offset(instr_offset),
      .program_counter(program_counter), .flag_carry(flag_carry),
      .flag_negative(flag_negative), .flag_overflow(flag_overflow),
      .flag_halfcarry(flag_halfcarry), .flag_transfer(flag_transfer),
      .pc_load(pc_load), .pc_target(pc_target), .fetch_flush(fetch_flush),
      .pipe_stall(pipe_stall), .branch_done(branch_done),
      .branch_taken(branch_taken), .flag_write_en(flag_write_en),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_waitrequest(avs_waitrequest)
   );
`default_nettype wire

/* File: cbu_branch_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit
#(
   parameter int PC_WIDTH = cbu_pkg::CBU_PC_WIDTH,
   parameter int K_WIDTH = cbu_pkg::CBU_K_WIDTH
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // decode side
   input wire logic instr_valid,
   input wire cbu_pkg::cbu_cond_type instr_cond,
   input wire logic [K_WIDTH-1:0] instr_offset,
   input wire logic [PC_WIDTH-1:0] program_counter,
   // status register flags
   input wire logic flag_carry,
   input wire logic flag_negative,
   input wire logic flag_overflow,
   input wire logic flag_halfcarry,
   input wire logic flag_transfer,
   // fetch side
   output logic pc_load,
   output logic [PC_WIDTH-1:0] pc_target,
   output logic fetch_flush,
   output logic pipe_stall,
   output logic branch_done,
   output logic branch_taken,
   output logic flag_write_en,
   // avalon-mm slave
   input wire logic [cbu_pkg::CBU_ADDR_WIDTH-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [cbu_pkg::CBU_DATA_WIDTH-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [cbu_pkg::CBU_DATA_WIDTH-1:0] avs_readdata,
   output logic avs_waitrequest
);
   import cbu_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (PC_WIDTH < 2 || PC_WIDTH > 32)
   begin : g_bad_pc
      $error("PC_WIDTH must be 2..32");
   end
   if (K_WIDTH < 2 || K_WIDTH > PC_WIDTH)
   begin : g_bad_k
      $error("K_WIDTH must be 2..PC_WIDTH");
   end

   // ------------------------------------------------------------
   // target arithmetic
   // ------------------------------------------------------------
   // sign-extend k and add one; wraps modulo program space
   function automatic logic [PC_WIDTH-1:0] rel_target
   (
      input logic [PC_WIDTH-1:0] pc,
      input logic [K_WIDTH-1:0] k
   );
      logic [PC_WIDTH-1:0] k_ext;
      k_ext = {{(PC_WIDTH-K_WIDTH){k[K_WIDTH-1]}}, k};
      rel_target = pc + k_ext + {{(PC_WIDTH-1){1'b0}}, 1'b1};
   endfunction : rel_target

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cbu_state_type state;        // issue or redirect cycle
   logic ctrl_enable;           // unit accepts branches
   logic last_taken;            // outcome of newest branch
   logic badop_seen;            // sticky unknown code flag
   logic [31:0] taken_count;    // taken branches since clear
   logic [31:0] fall_count;     // fall-through branches since clear
   logic [PC_WIDTH-1:0] last_target; // newest computed target

   // ------------------------------------------------------------
   // condition evaluation
   // ------------------------------------------------------------
   wire logic cond_taken;  // flags satisfy the code
   wire logic cond_known;  // code is one of ours

   cbu_cond_eval u_eval
   (
      .cond(instr_cond),
      .flag_carry(flag_carry),
      .flag_negative(flag_negative),
      .flag_overflow(flag_overflow),
      .flag_halfcarry(flag_halfcarry),
      .flag_transfer(flag_transfer),
      .taken(cond_taken),
      .known(cond_known)
   );

   // ------------------------------------------------------------
   // decode of the incoming branch
   // ------------------------------------------------------------
   // a new branch is only accepted in the issue state; during the
   // redirect cycle the fetch stage is stalled and must not issue
   wire logic accept;
   wire logic go_taken;
   wire logic go_fall;
   wire logic [PC_WIDTH-1:0] next_target;
   assign accept = instr_valid && ctrl_enable && (state == st_issue);
   assign go_taken = accept && cond_known && cond_taken;
   assign go_fall = accept && !(cond_known && cond_taken);
   assign next_target = rel_target(program_counter, instr_offset);

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // waitrequest is held high for one cycle of every request, so the
   // answer lands on a flop and the read mux stays off the bus path
   wire logic bus_req;
   wire logic bus_fire;
   wire logic wr_fire;
   wire logic hit_ctrl;
   wire logic hit_status;
   wire logic hit_taken;
   wire logic hit_fall;
   wire logic hit_target;
   wire logic clr_counts;
   wire logic clr_badop;
   wire logic [31:0] next_readdata;
   assign bus_req = avs_read || avs_write;
   assign bus_fire = bus_req && avs_waitrequest;
   // a write lands only at the edge that completes the transfer
   assign wr_fire = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign hit_ctrl = (avs_address == CBU_OFS_CTRL);
   assign hit_status = (avs_address == CBU_OFS_STATUS);
   assign hit_taken = (avs_address == CBU_OFS_TAKEN_CNT);
   assign hit_fall = (avs_address == CBU_OFS_FALL_CNT);
   assign hit_target = (avs_address == CBU_OFS_LAST_TARGET);
   assign clr_counts = wr_fire && hit_ctrl &&
                       avs_writedata[CBU_CTRL_CLR_CNT_BIT];
   assign clr_badop = wr_fire && hit_status &&
                      avs_writedata[CBU_STAT_BADOP_BIT];
   // unmapped addresses read as zero, writes there are dropped
   assign next_readdata =
      hit_ctrl ? {31'h0000_0000, ctrl_enable} :
      hit_status ? {29'h0000_0000, badop_seen, last_taken,
                    (state == st_redirect)} :
      hit_taken ? taken_count :
      hit_fall ? fall_count :
      hit_target ? {{(32-PC_WIDTH){1'b0}}, last_target} :
      32'h0000_0000;

   // ------------------------------------------------------------
   // branch sequencer
   // ------------------------------------------------------------
   // taken: first cycle loads pc and flushes the fetched word,
   // second cycle is the bubble; fall-through finishes at once
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= st_issue;
         pc_load <= 1'b0;
         fetch_flush <= 1'b0;
         pipe_stall <= 1'b0;
         branch_done <= 1'b0;
      end
      else if (clk_en)
      begin
         case (state)
            st_issue:
            begin
               pc_load <= go_taken;
               fetch_flush <= go_taken;
               pipe_stall <= go_taken;
               branch_done <= go_fall;
               if (go_taken)
               begin
                  state <= st_redirect;
               end
            end
            st_redirect:
            begin
               pc_load <= 1'b0;
               fetch_flush <= 1'b0;
               pipe_stall <= 1'b0;
               branch_done <= 1'b1;
               state <= st_issue;
            end
            default:
            begin
               state <= st_issue;
               pc_load <= 1'b0;
               fetch_flush <= 1'b0;
               pipe_stall <= 1'b0;
               branch_done <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // target and outcome
   // ------------------------------------------------------------
   // target is latched for every accepted branch, taken or not
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_target <= '0;
         last_target <= '0;
         last_taken <= 1'b0;
         branch_taken <= 1'b0;
      end
      else if (clk_en)
      begin
         branch_taken <= go_taken;
         if (accept)
         begin
            pc_target <= next_target;
            last_target <= next_target;
            last_taken <= go_taken;
         end
      end
   end

   // ------------------------------------------------------------
   // status flag write port
   // ------------------------------------------------------------
   // the unit owns a write strobe into the status register only so
   // that it is visibly idle; no branch ever modifies a flag
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_write_en <= 1'b0;
      end
      else if (clk_en)
      begin
         flag_write_en <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // statistics counters
   // ------------------------------------------------------------
   // a clear and an event in the same cycle leave a count of one
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         taken_count <= CBU_RST_COUNT;
         fall_count <= CBU_RST_COUNT;
      end
      else if (clk_en)
      begin
         if (clr_counts)
         begin
            taken_count <= {31'h0000_0000, go_taken};
            fall_count <= {31'h0000_0000, go_fall};
         end
         else
         begin
            taken_count <= taken_count + {31'h0000_0000, go_taken};
            fall_count <= fall_count + {31'h0000_0000, go_fall};
         end
      end
   end

   // ------------------------------------------------------------
   // control and sticky status
   // ------------------------------------------------------------
   // unknown code sets win over a software clear in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_enable <= CBU_RST_ENABLE;
         badop_seen <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_fire && hit_ctrl)
         begin
            ctrl_enable <= avs_writedata[CBU_CTRL_ENABLE_BIT];
         end
         if (accept && !cond_known)
         begin
            badop_seen <= 1'b1;
         end
         else if (clr_badop)
         begin
            badop_seen <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // avalon answer
   // ------------------------------------------------------------
   // waitrequest idles high; it drops for exactly one cycle after
   // a request is seen, which is the cycle the master completes in
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         avs_waitrequest <= !bus_fire;
         if (bus_fire && avs_read)
         begin
            avs_readdata <= next_readdata;
         end
      end
   end

endmodule : cbu_branch_unit
`default_nettype wire

/* File: cbu_cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// flag test for one branch code, purely combinational
// ------------------------------------------------------------
module cbu_cond_eval
(
   input wire cbu_pkg::cbu_cond_type cond,
   input wire logic flag_carry,
   input wire logic flag_negative,
   input wire logic flag_overflow,
   input wire logic flag_halfcarry,
   input wire logic flag_transfer,
   output logic taken,
   output logic known
);
   import cbu_pkg::*;

   // signed compare uses the sign-corrected flag
   wire logic signed_less;
   assign signed_less = flag_negative ^ flag_overflow;

   // ------------------------------------------------------------
   // condition selection
   // ------------------------------------------------------------
   always_comb
   begin
      taken = 1'b0;
      known = 1'b1;
      case (cond)
         branch_carry_set: taken = flag_carry;
         branch_carry_clear: taken = ~flag_carry;
         branch_same_or_higher: taken = ~flag_carry;
         branch_lower: taken = flag_carry;
         branch_negative: taken = flag_negative;
         branch_positive: taken = ~flag_negative;
         branch_signed_ge: taken = ~signed_less;
         branch_signed_lt: taken = signed_less;
         branch_halfcarry_set: taken = flag_halfcarry;
         branch_halfcarry_clear: taken = ~flag_halfcarry;
         branch_transfer_set: taken = flag_transfer;
         default: known = 1'b0;  // unknown codes always fall through
      endcase
   end

endmodule : cbu_cond_eval
`default_nettype wire

/* File: cbu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// fetch stage and status register around the unit
// ----------
module cbu_core_model
#(
   parameter int PC_WIDTH = cbu_pkg::CBU_PC_WIDTH
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic seed_en,
   input wire logic [PC_WIDTH-1:0] seed_pc,
   input wire logic [4:0] seed_flags,
   input wire logic pc_load,
   input wire logic [PC_WIDTH-1:0] pc_target,
   input wire logic flag_write_en,
   output logic [PC_WIDTH-1:0] program_counter,
   output logic [4:0] sreg
);
   import cbu_pkg::*;
   // sreg is carry, negative, overflow, halfcarry, transfer
   // the unit supplies no flag data, so a stray write wipes them
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         program_counter <= '0;
         sreg <= 5'h00;
      end
      else if (seed_en)
      begin
         program_counter <= seed_pc;
         sreg <= seed_flags;
      end
      else
      begin
         if (pc_load)
            program_counter <= pc_target; // redirect accepted
         if (flag_write_en)
            sreg <= 5'h00;
      end
   end
endmodule : cbu_core_model
`default_nettype wire

/* File: cbu_pkg.sv */
// ------------------------------------------------------------
// shared constants and types for the conditional branch unit
// ------------------------------------------------------------
package cbu_pkg;

   // ------------------------------------------------------------
   // branch condition codes handed over by decode
   // ------------------------------------------------------------
   typedef enum logic [3:0]
   {
      branch_carry_set,
      branch_carry_clear,
      branch_same_or_higher,
      branch_lower,
      branch_negative,
      branch_positive,
      branch_signed_ge,
      branch_signed_lt,
      branch_halfcarry_set,
      branch_halfcarry_clear,
      branch_transfer_set,
      branch_none
   } cbu_cond_type;

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic
   {
      st_issue,
      st_redirect
   } cbu_state_type;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int CBU_PC_WIDTH = 13;   // word address of 16 kbyte space
   localparam int CBU_K_WIDTH = 7;     // relative offset field
   localparam int CBU_ADDR_WIDTH = 5;  // byte address on the bus
   localparam int CBU_DATA_WIDTH = 32;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [4:0] CBU_OFS_CTRL = 5'h00;
   localparam logic [4:0] CBU_OFS_STATUS = 5'h04;
   localparam logic [4:0] CBU_OFS_TAKEN_CNT = 5'h08;
   localparam logic [4:0] CBU_OFS_FALL_CNT = 5'h0C;
   localparam logic [4:0] CBU_OFS_LAST_TARGET = 5'h10;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CBU_CTRL_ENABLE_BIT = 0;   // unit accepts branches
   localparam int CBU_CTRL_CLR_CNT_BIT = 1;  // write 1 clears counters
   localparam int CBU_STAT_BUSY_BIT = 0;     // redirect cycle in progress
   localparam int CBU_STAT_TAKEN_BIT = 1;    // last branch was taken
   localparam int CBU_STAT_BADOP_BIT = 2;    // sticky unknown code seen

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic CBU_RST_ENABLE = 1'b1;
   localparam logic [31:0] CBU_RST_COUNT = 32'h0000_0000;

   // ------------------------------------------------------------
   // cycle counts
   // ------------------------------------------------------------
   localparam int CBU_CYCLES_NOT_TAKEN = 1;
   localparam int CBU_CYCLES_TAKEN = 2;

endpackage : cbu_pkg

/* File: cbu_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cbu_pkg::*;
   // ----------
   // stimulus table: code, flags {c,n,v,h,t}, taken
   // ----------
   typedef struct packed
   {
      cbu_cond_type c;
      logic [4:0] f;
      logic t;
   } cbu_row_type;
   cbu_row_type rows [23] = '{
      '{branch_carry_set, 5'h10, 1'b1}, '{branch_carry_set, 5'h0F, 1'b0},
      '{branch_carry_clear, 5'h00, 1'b1}, '{branch_carry_clear, 5'h10, 1'b0},
      '{branch_same_or_higher, 5'h0F, 1'b1},
      '{branch_same_or_higher, 5'h10, 1'b0},
      '{branch_lower, 5'h10, 1'b1}, '{branch_lower, 5'h0F, 1'b0},
      '{branch_negative, 5'h08, 1'b1}, '{branch_negative, 5'h17, 1'b0},
      '{branch_positive, 5'h17, 1'b1}, '{branch_positive, 5'h08, 1'b0},
      '{branch_signed_ge, 5'h0C, 1'b1}, '{branch_signed_ge, 5'h08, 1'b0},
      '{branch_signed_lt, 5'h04, 1'b1}, '{branch_signed_lt, 5'h0C, 1'b0},
      '{branch_halfcarry_set, 5'h02, 1'b1},
      '{branch_halfcarry_set, 5'h1D, 1'b0},
      '{branch_halfcarry_clear, 5'h1D, 1'b1},
      '{branch_halfcarry_clear, 5'h02, 1'b0},
      '{branch_transfer_set, 5'h01, 1'b1},
      '{branch_transfer_set, 5'h1E, 1'b0}, '{branch_none, 5'h1F, 1'b0}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1; // low freezes every flop of the unit
   logic instr_valid = 1'b0;
   cbu_cond_type instr_cond = branch_none;
   logic [6:0] instr_offset = 7'h00;
   logic seed_en = 1'b0;
   logic [12:0] seed_pc = 13'h0000;
   logic [4:0] seed_flags = 5'h00;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [12:0] program_counter, pc_target;
   logic [4:0] sreg;
   logic pc_load, fetch_flush, pipe_stall, branch_done, branch_taken;
   logic flag_write_en, avs_waitrequest;
   logic [31:0] avs_readdata, q;
   logic [6:0] kv;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   cbu_branch_unit dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr_cond(instr_cond),
      .instr_offset(instr_offset), .program_counter(program_counter),
      .flag_carry(sreg[4]), .flag_negative(sreg[3]), .flag_overflow(sreg[2]),
      .flag_halfcarry(sreg[1]), .flag_transfer(sreg[0]), .pc_load(pc_load),
      .pc_target(pc_target), .fetch_flush(fetch_flush),
      .pipe_stall(pipe_stall), .branch_done(branch_done),
      .branch_taken(branch_taken), .flag_write_en(flag_write_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   cbu_core_model core (.clk(clk), .rst_n(rst_n), .seed_en(seed_en),
      .seed_pc(seed_pc), .seed_flags(seed_flags), .pc_load(pc_load),
      .pc_target(pc_target), .flag_write_en(flag_write_en),
      .program_counter(program_counter), .sreg(sreg));
   // ----------
   // helpers
   // ----------
   task stop_test;
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // one bus transfer, held until a rising edge samples waitrequest low
   task automatic av(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   // one branch from a seeded pc and flag set, entered at an edge
   task automatic branch(input cbu_cond_type c, input logic [4:0] f,
      input logic [12:0] pc, input logic [6:0] k, input logic t);
      logic [12:0] e;
      e = pc + {{6{k[6]}}, k} + 13'h0001;
      seed_en <= 1'b1;
      seed_pc <= pc;
      seed_flags <= f;
      @(posedge clk);
      seed_en <= 1'b0;
      instr_valid <= 1'b1;
      instr_cond <= c;
      instr_offset <= k;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1 chk(pc_load === t && pc_target === e, "outcome");
      chk(branch_done === !t, "one cycle fall-through");
      chk(fetch_flush === t && branch_taken === t, "strobes");
      if (t)
      begin
         @(posedge clk);
         #1 chk(branch_done === 1'b1 && pipe_stall === 1'b0, "taken end");
      end
      @(posedge clk);
      chk(sreg === f, "flags altered");
   endtask : branch
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fail_count++;
         stop_test();
      end
   end
   // ----------
   // main sequence
   // ----------
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // odd rows reach forward, even rows back, row 0 wraps below zero
      foreach (rows[i])
      begin
         kv = i[0] ? 7'h3F : 7'h40;
         branch(rows[i].c, rows[i].f, 13'(i * 341), kv, rows[i].t);
      end
      // fall-through, then taken back to back, then one during the stall
      seed_en <= 1'b1;
      seed_flags <= 5'h00;
      @(posedge clk);
      seed_en <= 1'b0;
      instr_valid <= 1'b1;
      instr_cond <= branch_carry_set;
      @(posedge clk);
      instr_cond <= branch_carry_clear;
      #1 chk(branch_done === 1'b1 && pc_load === 1'b0, "first done");
      @(posedge clk);
      #1 chk(pc_load === 1'b1 && pipe_stall === 1'b1, "second taken");
      @(posedge clk);
      instr_valid <= 1'b0;
      #1 chk(pc_load === 1'b0 && branch_done === 1'b1, "second end");
      @(posedge clk);
      #1 chk(pc_load === 1'b0 && branch_done === 1'b0, "stall ignored");
      // a branch offered while frozen leaves no trace
      @(posedge clk);
      clk_en <= 1'b0;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      clk_en <= 1'b1;
      @(posedge clk);
      #1 chk(pc_load === 1'b0 && branch_done === 1'b0, "frozen branch");
      // reset in mid-run
      @(posedge clk);
      rst_n <= 1'b0;
      #1 chk(pc_target === 13'h0000 && avs_waitrequest === 1'b1, "reset out");
      chk(pc_load === 1'b0 && flag_write_en === 1'b0, "reset pulses");
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // register bus
      av(1'b0, CBU_OFS_CTRL, 32'h0000_0000, q);
      chk(q === {31'h0000_0000, CBU_RST_ENABLE}, "control reset");
      av(1'b0, 5'h14, 32'h0000_0000, q);
      chk(q === 32'h0000_0000, "unmapped read");
      av(1'b1, CBU_OFS_CTRL, 32'h0000_0000, q);
      instr_valid <= 1'b1;
      instr_cond <= branch_carry_clear;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1 chk(pc_load === 1'b0, "disabled redirect");
      @(posedge clk);
      #1 chk(branch_done === 1'b0, "disabled done");
      av(1'b1, CBU_OFS_CTRL, 32'h0000_0001, q);
      branch(branch_carry_clear, 5'h00, 13'h0010, 7'h01, 1'b1);
      av(1'b1, CBU_OFS_CTRL, 32'h0000_0003, q);
      branch(branch_none, 5'h1F, 13'h0020, 7'h7F, 1'b0);
      av(1'b0, CBU_OFS_TAKEN_CNT, 32'h0000_0000, q);
      chk(q === CBU_RST_COUNT, "taken count cleared");
      av(1'b0, CBU_OFS_FALL_CNT, 32'h0000_0000, q);
      chk(q === 32'h0000_0001, "fall count");
      av(1'b0, CBU_OFS_STATUS, 32'h0000_0000, q);
      chk(q[2:0] === 3'h4, "status after unknown code");
      stop_test();
   end
endmodule : tb
`default_nettype wire
